// ### src/adc_readout_regs.svh
// timing counts and field sizes for the serial result readout
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH

`define CLK_PERIOD_NS     20
`define CONV_TIME_NS      2000
`define CONV_CYCLES       ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_BITS       16
`define BUSY_RELEASE_EDGE 17
`define PLAIN_RELEASE_EDGE 16
`define BUF_DEPTH         2

`endif

// ### src/adc_readout_pkg.sv
// types shared by the serial result readout
package adc_readout_pkg;

    typedef enum logic [2:0] {
        ST_ACQ,
        ST_CONVERT,
        ST_SEL_WAIT,
        ST_SEL_SHIFT,
        ST_CHAIN
    } state_t;

    typedef enum logic [1:0] {
        MODE_SELECT,
        MODE_SELECT_BUSY,
        MODE_CHAIN,
        MODE_CHAIN_BUSY
    } mode_t;

endpackage

// ### src/adc_readout.sv
// serial result readout of a sampling converter, select and chain modes
`include "adc_readout_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_readout
    import adc_readout_pkg::*;
#(
    parameter int RESULT_W    = `RESULT_BITS,
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    // clock and reset
    input  wire logic                REF_CLK_IN,
    input  wire logic                RESET_N_IN,
    // host pins, asynchronous to the clock
    input  wire logic                CONV_TRIGGER_IN,
    input  wire logic                SERIAL_IN_SELECT_IN,
    input  wire logic                SCK_IN,
    // result from the converter core
    input  wire logic [RESULT_W-1:0] RESULT_DATA_IN,
    input  wire logic                RESULT_VALID_IN,
    output logic                     RESULT_READY_OUT,
    // converter core control
    output logic                     SAMPLE_OUT,
    output logic                     CONVERTER_POWER_OUT,
    // serial output pin
    output logic                     SERIAL_OUT_OUT,
    output logic                     SERIAL_OUT_OE_N_OUT
);

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);

    // reset release through two flops
    logic       rst_meta_r;
    logic       rst_n_r;

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // pin synchronisers; only stage two and the history flop are read
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_prev_r;

    always_ff @(posedge REF_CLK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
            pin_prev_r <= 3'h0;
        end else begin
            pin_meta_r <= {SCK_IN, SERIAL_IN_SELECT_IN, CONV_TRIGGER_IN};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    logic trig_lvl;
    logic sel_lvl;
    logic sck;
    logic trig_rise;
    logic sel_rise;
    logic sel_fall;
    logic sck_fall;

    // edges seen in the cycle the second flop changes, against the history flop
    assign trig_lvl  = pin_sync_r[0];
    assign sel_lvl   = pin_sync_r[1];
    assign sck       = pin_sync_r[2];
    assign trig_rise = pin_sync_r[0] & ~pin_prev_r[0];
    assign sel_rise  = pin_sync_r[1] & ~pin_prev_r[1];
    assign sel_fall  = ~pin_sync_r[1] & pin_prev_r[1];
    assign sck_fall  = ~pin_sync_r[2] & pin_prev_r[2];

    // two-entry result buffer between core and shifter
    logic [RESULT_W-1:0] buf_mem_r [`BUF_DEPTH];
    logic [RESULT_W-1:0] buf_mem_nxt [`BUF_DEPTH];
    logic                wr_ptr_r, wr_ptr_nxt;
    logic                rd_ptr_r, rd_ptr_nxt;
    logic [1:0]          count_r, count_nxt;
    logic                ready_r, ready_nxt;
    logic                buf_push;
    logic                buf_pop;
    logic                buf_valid;

    assign buf_valid = (count_r != 2'h0);
    assign buf_push  = RESULT_VALID_IN & ready_r;

    // ready is registered, so it reflects room after this cycle
    always_comb begin
        buf_mem_nxt = buf_mem_r;
        wr_ptr_nxt  = wr_ptr_r;
        rd_ptr_nxt  = rd_ptr_r;
        count_nxt   = count_r;
        if (buf_push) begin
            buf_mem_nxt[wr_ptr_r] = RESULT_DATA_IN;
            wr_ptr_nxt            = ~wr_ptr_r;
        end
        if (buf_pop) begin
            rd_ptr_nxt = ~rd_ptr_r;
        end
        count_nxt = count_r + {1'b0, buf_push} - {1'b0, buf_pop};
        ready_nxt = (count_nxt != 2'h2);
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            buf_mem_r <= '{default: '0};
            wr_ptr_r  <= 1'b0;
            rd_ptr_r  <= 1'b0;
            count_r   <= 2'h0;
            ready_r   <= 1'b0;
        end else begin
            buf_mem_r <= buf_mem_nxt;
            wr_ptr_r  <= wr_ptr_nxt;
            rd_ptr_r  <= rd_ptr_nxt;
            count_r   <= count_nxt;
            ready_r   <= ready_nxt;
        end
    end

    // conversion, mode and shift state
    state_t              state_r, state_nxt;
    mode_t               mode_r, mode_nxt;
    logic [CNT_W-1:0]    conv_cnt_r, conv_cnt_nxt;
    logic [4:0]          bit_cnt_r, bit_cnt_nxt;
    logic [RESULT_W-1:0] shreg_r, shreg_nxt;
    logic                flush_r, flush_nxt;
    logic                sout_r, sout_nxt;
    logic                oe_n_r, oe_n_nxt;
    logic                sample_r, sample_nxt;
    logic                power_r, power_nxt;
    logic [4:0]          release_edge;

    assign release_edge = (mode_r == MODE_SELECT_BUSY) ? 5'(`BUSY_RELEASE_EDGE)
                                                       : 5'(`PLAIN_RELEASE_EDGE);
    // completion waits for the core word; an empty buffer stalls it
    assign buf_pop = (state_r == ST_CONVERT) && (conv_cnt_r == CNT_W'(0)) && buf_valid;

    always_comb begin
        state_nxt    = state_r;
        mode_nxt     = mode_r;
        conv_cnt_nxt = conv_cnt_r;
        bit_cnt_nxt  = bit_cnt_r;
        shreg_nxt    = shreg_r;
        flush_nxt    = flush_r;
        sout_nxt     = sout_r;
        oe_n_nxt     = oe_n_r;
        sample_nxt   = 1'b0;
        power_nxt    = 1'b0;
        if (trig_rise) begin
            // mode straps taken at the trigger edge
            state_nxt    = ST_CONVERT;
            conv_cnt_nxt = CNT_W'(CONV_CYCLES);
            sample_nxt   = 1'b1;
            power_nxt    = 1'b1;
            bit_cnt_nxt  = 5'h0;
            if (sel_lvl) begin
                mode_nxt = MODE_SELECT;
                oe_n_nxt = 1'b1;
            end else begin
                mode_nxt = sck ? MODE_CHAIN_BUSY : MODE_CHAIN;
                sout_nxt = 1'b0;
                oe_n_nxt = 1'b0;
            end
        end else begin
            case (state_r)
                ST_CONVERT: begin
                    power_nxt = 1'b1;
                    if (conv_cnt_r != CNT_W'(0)) begin
                        conv_cnt_nxt = conv_cnt_r - CNT_W'(1);
                    end else if (buf_valid) begin
                        shreg_nxt = buf_mem_r[rd_ptr_r];
                        power_nxt = 1'b0;
                        if (mode_r == MODE_SELECT && !sel_lvl) begin
                            // selected before completion: busy edge
                            mode_nxt  = MODE_SELECT_BUSY;
                            state_nxt = ST_SEL_SHIFT;
                            sout_nxt  = 1'b0;
                            oe_n_nxt  = 1'b0;
                        end else if (mode_r == MODE_SELECT) begin
                            state_nxt = ST_SEL_WAIT;
                        end else if (mode_r == MODE_CHAIN) begin
                            state_nxt = ST_CHAIN;
                            flush_nxt = 1'b0;
                            sout_nxt  = buf_mem_r[rd_ptr_r][RESULT_W-1];
                        end else begin
                            state_nxt = ST_CHAIN;
                            flush_nxt = 1'b1;
                            sout_nxt  = sel_lvl;
                        end
                    end
                end
                ST_SEL_WAIT: begin
                    if (sel_fall) begin
                        sout_nxt    = shreg_r[RESULT_W-1];
                        shreg_nxt   = {shreg_r[RESULT_W-2:0], 1'b0};
                        oe_n_nxt    = 1'b0;
                        bit_cnt_nxt = 5'h0;
                        state_nxt   = ST_SEL_SHIFT;
                    end
                end
                ST_SEL_SHIFT: begin
                    if (sel_rise) begin
                        oe_n_nxt  = 1'b1;
                        state_nxt = ST_ACQ;
                    end else if (sck_fall) begin
                        bit_cnt_nxt = bit_cnt_r + 5'h1;
                        if (bit_cnt_nxt == release_edge) begin
                            oe_n_nxt  = 1'b1;
                            state_nxt = ST_ACQ;
                        end else begin
                            // bit changes only at a fall, stable at the rise
                            sout_nxt  = shreg_r[RESULT_W-1];
                            shreg_nxt = {shreg_r[RESULT_W-2:0], 1'b0};
                        end
                    end
                end
                ST_CHAIN: begin
                    if (flush_r && !sck_fall) begin
                        sout_nxt = sel_lvl;
                    end else if (flush_r) begin
                        // start bit flushed, MSB follows
                        flush_nxt   = 1'b0;
                        sout_nxt    = shreg_r[RESULT_W-1];
                        bit_cnt_nxt = 5'h1;
                    end else if (sck_fall) begin
                        shreg_nxt = {shreg_r[RESULT_W-2:0], sel_lvl};
                        sout_nxt  = shreg_r[RESULT_W-2];
                        if (bit_cnt_r != 5'h1F) begin
                            bit_cnt_nxt = bit_cnt_r + 5'h1;
                        end
                    end
                end
                default: begin
                    // acquisition: idle and powered down
                    state_nxt = ST_ACQ;
                end
            endcase
            // both pins low drive the line low in every state, chain included
            if (!trig_lvl && !sel_lvl) begin
                sout_nxt = 1'b0;
                oe_n_nxt = 1'b0;
            end else if (state_r == ST_ACQ || (state_r == ST_SEL_WAIT && !sel_fall)) begin
                oe_n_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r    <= ST_ACQ;
            mode_r     <= MODE_SELECT;
            conv_cnt_r <= '0;
            bit_cnt_r  <= 5'h0;
            shreg_r    <= '0;
            flush_r    <= 1'b0;
            sout_r     <= 1'b0;
            oe_n_r     <= 1'b1;
            sample_r   <= 1'b0;
            power_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            mode_r     <= mode_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            shreg_r    <= shreg_nxt;
            flush_r    <= flush_nxt;
            sout_r     <= sout_nxt;
            oe_n_r     <= oe_n_nxt;
            sample_r   <= sample_nxt;
            power_r    <= power_nxt;
        end
    end

    // all outputs straight from flops
    assign RESULT_READY_OUT    = ready_r;
    assign SAMPLE_OUT          = sample_r;
    assign CONVERTER_POWER_OUT = power_r;
    assign SERIAL_OUT_OUT      = sout_r;
    assign SERIAL_OUT_OE_N_OUT = oe_n_r;

endmodule

`default_nettype wire

// ### test/adc_readout_props.sv
// pin-level assertion checker for the serial result readout
`timescale 1ns/100ps
`default_nettype none
module adc_readout_props (
    // clock, reset and host pins
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CONV_TRIGGER_IN,
    input wire logic SERIAL_IN_SELECT_IN,
    input wire logic SCK_IN,
    // converter control and serial output
    input wire logic SAMPLE_OUT,
    input wire logic CONVERTER_POWER_OUT,
    input wire logic SERIAL_OUT_OUT,
    input wire logic SERIAL_OUT_OE_N_OUT
);
    logic       sel_mode_r;
    logic       busy_r;
    logic [6:0] sck_h_r;
    wire        fell_win = |(sck_h_r[6:1] & ~sck_h_r[5:0]);
    // mode from the raw pins, ahead of the design's two-flop sync
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sel_mode_r <= 1'b1;
            busy_r     <= 1'b0;
            sck_h_r    <= 7'h00;
        end else begin
            sck_h_r <= {sck_h_r[5:0], SCK_IN};
            if ($rose(CONV_TRIGGER_IN)) begin
                sel_mode_r <= SERIAL_IN_SELECT_IN;
                busy_r     <= SCK_IN;
            end
        end
    end
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    // sync latency gives a window of a few cycles, never open-ended
    a_select_floats: assert property (
        $rose(CONV_TRIGGER_IN) && SERIAL_IN_SELECT_IN |-> ##[2:5] (SAMPLE_OUT && SERIAL_OUT_OE_N_OUT))
        else $error("select start left output driven");
    a_chain_drives: assert property (
        !sel_mode_r && CONV_TRIGGER_IN && $past(CONV_TRIGGER_IN, 6) |-> !SERIAL_OUT_OE_N_OUT)
        else $error("chain mode output floating");
    a_idle_low: assert property (
        (!CONV_TRIGGER_IN && !SERIAL_IN_SELECT_IN) [*8] |-> !SERIAL_OUT_OE_N_OUT && !SERIAL_OUT_OUT)
        else $error("idle output not driven low");
    a_power_rise: assert property ($rose(CONVERTER_POWER_OUT) |-> SAMPLE_OUT)
        else $error("converter powered without a sample");
    a_sel_release: assert property (
        sel_mode_r && CONV_TRIGGER_IN && $rose(SERIAL_IN_SELECT_IN) |-> ##[2:5] SERIAL_OUT_OE_N_OUT)
        else $error("select rise did not release output");
    a_bit_holds: assert property (
        sel_mode_r && !SERIAL_OUT_OE_N_OUT && !$past(SERIAL_OUT_OE_N_OUT) && $changed(SERIAL_OUT_OUT)
        |-> fell_win) else $error("output bit moved without a clock fall");
    a_busy_low: assert property (
        sel_mode_r && CONV_TRIGGER_IN && !SERIAL_IN_SELECT_IN && $fell(CONVERTER_POWER_OUT)
        |-> ##[0:3] (!SERIAL_OUT_OE_N_OUT && !SERIAL_OUT_OUT)) else $error("no busy low at end");
    a_start_bit: assert property (
        !sel_mode_r && busy_r && SERIAL_IN_SELECT_IN && $fell(CONVERTER_POWER_OUT)
        |-> ##[0:4] (!SERIAL_OUT_OE_N_OUT && SERIAL_OUT_OUT)) else $error("no chain start bit");
    c_busy_chain: cover property (!sel_mode_r && busy_r && $fell(CONVERTER_POWER_OUT));
    c_plain_chain: cover property (!sel_mode_r && !busy_r && $fell(CONVERTER_POWER_OUT));
    c_sel_release: cover property (sel_mode_r && $rose(SERIAL_OUT_OE_N_OUT));
endmodule
bind adc_readout adc_readout_props props_u (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .SCK_IN(SCK_IN),
    .CONV_TRIGGER_IN(CONV_TRIGGER_IN), .SERIAL_IN_SELECT_IN(SERIAL_IN_SELECT_IN),
    .SAMPLE_OUT(SAMPLE_OUT), .CONVERTER_POWER_OUT(CONVERTER_POWER_OUT),
    .SERIAL_OUT_OUT(SERIAL_OUT_OUT), .SERIAL_OUT_OE_N_OUT(SERIAL_OUT_OE_N_OUT));
`default_nettype wire

// ### test/core_result_model.sv
// converter core stand-in, holds each word offered while it holds none until taken; offers while holding are dropped
`timescale 1ns/100ps
`default_nettype none
module core_result_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // bench request and buffer handshake
    input  wire logic        offer_in,
    input  wire logic [15:0] word_in,
    input  wire logic        ready_in,
    output logic      [15:0] data_out,
    output logic             valid_out
);
    logic [15:0] data_r, data_nxt;
    logic        valid_r, valid_nxt;
    // after a take the bus shows the inverse word, so a stale copy never passes
    always_comb begin
        data_nxt  = (valid_r && ready_in) ? ~data_r : data_r;
        valid_nxt = valid_r && !ready_in;
        if (offer_in && !valid_r) begin
            data_nxt  = word_in;
            valid_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_r  <= 16'h0000;
            valid_r <= 1'b0;
        end else begin
            data_r  <= data_nxt;
            valid_r <= valid_nxt;
        end
    end
    assign data_out  = data_r;
    assign valid_out = valid_r;
endmodule
`default_nettype wire

// ### test/adc_readout_bench.sv
// self-checking bench for the serial result readout
`timescale 1ns/100ps
`default_nettype none
module adc_readout_bench;
    // long enough that pin activity stays in the first quarter of conversion
    localparam int CONV = 40;
    logic        clk = 1'b0, rst_n = 1'b0, trig = 1'b0, sel = 1'b0, sck = 1'b0;
    logic        offer = 1'b0, rvalid, rready, smp, pwr, sout, oen;
    logic [15:0] word = 16'h0000, rdata;
    int          miscompares = 0, samples_checked = 0;
    always #10 clk = ~clk;
    adc_readout #(.CONV_CYCLES(CONV)) dut_u (
        .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CONV_TRIGGER_IN(trig),
        .SERIAL_IN_SELECT_IN(sel), .SCK_IN(sck), .RESULT_DATA_IN(rdata),
        .RESULT_VALID_IN(rvalid), .RESULT_READY_OUT(rready), .SAMPLE_OUT(smp),
        .CONVERTER_POWER_OUT(pwr), .SERIAL_OUT_OUT(sout), .SERIAL_OUT_OE_N_OUT(oen));
    core_result_model core_u (.clk_in(clk), .rst_n_in(rst_n), .offer_in(offer),
        .word_in(word), .ready_in(rready), .data_out(rdata), .valid_out(rvalid));
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask
    // serial clock frames: 4 cycles high, 4 low, bit taken before each rise
    task automatic rd(input int n, output logic [15:0] w);
        w = 16'h0000;
        repeat (n) begin
            w = {w[14:0], sout};
            sck = 1'b1;
            ticks(4);
            chk("bit across rise", w[0], sout);
            sck = 1'b0;
            ticks(4);
        end
    endtask
    task automatic push(input logic [15:0] w);
        word = w;
        offer = 1'b1;
        ticks(1);
        offer = 1'b0;
        ticks(1);
    endtask
    // trigger rise with mode pins set, then sit out the whole conversion
    task automatic start(input logic s, input logic k, input logic s_late);
        sel = s;
        sck = k;
        ticks(2);
        trig = 1'b1;
        ticks(3);
        chk("sample pulse", 16'h0001, smp);
        ticks(3);
        chk("float at start", s, oen);
        chk("power in conversion", 16'h0001, pwr);
        sel = s_late;
        sck = 1'b0;
        ticks(CONV + 8);
        chk("powered down", 16'h0000, pwr);
    endtask
    task automatic idle();
        trig = 1'b0;
        sel = 1'b0;
        ticks(6);
        chk("idle drive", 16'h0000, {oen, sout});
    endtask
    task automatic t_fill();
        push(16'hA5C3);
        push(16'h3C5A);
        push(16'h8001);
        ticks(4);
        chk("full refuses", 16'h0001, {rready, rvalid});
    endtask
    task automatic t_chain(input logic busy, input logic [15:0] exp);
        logic [15:0] w;
        start(1'b0, busy, 1'b1);
        if (busy) begin
            chk("start bit", 16'h0001, {oen, sout});
            rd(1, w);
        end
        rd(16, w);
        chk("chain word", exp, w);
        rd(16, w);
        chk("fed through", 16'hFFFF, w);
        sel = 1'b0;
        rd(16, w);
        idle();
    endtask
    task automatic t_select(input logic busy, input int n, input logic [15:0] exp);
        logic [15:0] w;
        start(1'b1, 1'b0, !busy);
        if (busy) begin
            chk("busy low", 16'h0000, {oen, sout});
            rd(1, w);
        end else begin
            sel = 1'b0;
            ticks(5);
        end
        rd(n, w);
        sel = (n < 16); // early release when cut short
        ticks(5);
        chk("select word", exp >> (16 - n), w);
        chk("released", 16'h0001, oen);
        idle();
    endtask
    initial begin
        ticks(8);
        rst_n = 1'b1;
        ticks(4);
        t_fill();
        t_chain(1'b0, 16'hA5C3);
        t_chain(1'b1, 16'h3C5A);
        t_select(1'b0, 16, 16'h8001);
        push(16'h7E24);
        t_select(1'b0, 5, 16'h7E24);
        push(16'hC3A5);
        t_select(1'b1, 16, 16'hC3A5);
        chk("drained", 16'h0001, rready);
        report_and_stop();
    end
    // far longer than the expected run of some 1450 cycles
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
